/* File: dv/serial_config_flash_port_tb.sv */
// Bench: host and memory joined by the link; writes then reads back.
// Assumes the host derives the link clock from clk.
`timescale 1ns/10ps
module serial_config_flash_port_tb;
  logic       clk;
  logic       nrst;
  logic       start;
  logic       write;
  logic       busy;
  logic       done;
  logic       armed;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic [7:0] exp_q[$];
  logic [7:0] mem[4];
  int         seed = 12;
  int         error_cnt;
  int         check_count;
  int         cycles;
  sflash_if sflash_if_i();
  sflash_host sflash_host_i(.clk(clk), .nrst(nrst), .start(start), .write(write),
    .addr(addr), .wdata(wdata), .busy(busy), .done(done), .rdata(rdata),
    .link(sflash_if_i.host));
  sflash_memory sflash_memory_i(.nrst(nrst), .armed(armed), .link(sflash_if_i.memory));
  sflash_sva sflash_sva_i(.clk(clk), .nrst(nrst),
    .serial_clock_in(sflash_if_i.serial_clock_in), .select_n(sflash_if_i.select_n),
    .serial_data_in(sflash_if_i.serial_data_in), .data_out(sflash_if_i.data_out),
    .data_oe_n(sflash_if_i.data_oe_n));
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  task automatic test_done();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : test_done
  // One frame; start held for a single rising edge
  task automatic frame(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    write = w;
    addr = a;
    wdata = d;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    check({7'h00, busy}, 8'h01);
    while (!done)
      @(negedge clk);
    check({7'h00, busy}, 8'h00);
  endtask : frame
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Results compared on the settled half of the cycle
  always @(negedge clk)
    if (done === 1'b1 && !write)
      check(rdata, exp_q.pop_front());
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      error_cnt++;
      test_done();
    end
  end
  initial
  begin
    nrst = 1'b1;
    start = 1'b0;
    write = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    // Falling reset after time zero so the memory's clear is not missed
    #1;
    nrst = 1'b0;
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    check({7'h00, armed}, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      mem[i] = 8'($random(seed));
      frame(1'b1, 8'(i * 85), mem[i]);
    end
    check({7'h00, armed}, 8'h01);
    $display("writes done");
    // Reverse order so a stale address shows up
    for (int i = 3; i >= 0; i--)
    begin
      exp_q.push_back(mem[i]);
      frame(1'b0, 8'(i * 85), 8'h00);
    end
    $display("reads done");
    test_done();
  end
endmodule : serial_config_flash_port_tb

/* File: dv/sflash_sva.sv */
// Link checks for the host and memory ends facing each other.
// Assumes the link clock is derived from clk, so clk sampling suffices.
`timescale 1ns/10ps
module sflash_sva (
  // System
  input wire logic clk,
  input wire logic nrst,
  // Link
  input wire logic serial_clock_in,
  input wire logic select_n,
  input wire logic serial_data_in,
  input wire logic data_out,
  input wire logic data_oe_n
);
  logic [4:0] rise_cnt;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // Rising link edges seen in the current frame
  always_ff @(posedge clk)
    if (!nrst || select_n)
      rise_cnt <= 5'h00;
    else if ($rose(serial_clock_in))
      rise_cnt <= rise_cnt + 5'h01;
  a_desel_tri: assert property (select_n && $past(select_n) |-> data_oe_n)
    else $error("data driven while deselected");
  a_clk_idle: assert property (select_n |-> !serial_clock_in)
    else $error("link clock moves outside a frame");
  a_rise_sel: assert property ($rose(serial_clock_in) |-> !select_n)
    else $error("link clock rise while deselected");
  a_din_stable: assert property ($rose(serial_clock_in) |-> $stable(serial_data_in))
    else $error("input data moved at rising edge");
  a_dout_stable: assert property ($rose(serial_clock_in) && !data_oe_n |-> $stable(data_out))
    else $error("output data moved at rising edge");
  a_frame_bits: assert property ($rose(select_n) |-> rise_cnt == 5'h18)
    else $error("frame not 24 bits");
  a_oe_late: assert property (!data_oe_n && !select_n |-> rise_cnt >= 5'h10)
    else $error("data driven before address ends");
  a_frame_end: assert property ($fell(select_n) |-> ##[1:200] $rose(select_n))
    else $error("frame never closed");
  c_frame: cover property ($fell(select_n));
  c_drive: cover property (!data_oe_n);
  c_close: cover property ($rose(select_n));
endmodule : sflash_sva

/* File: hw/sflash_host.sv */
// Host end: frames one command, address and data byte per request.
// Assumes clk 20 MHz; link clock divided from clk and driven out.
`timescale 1ns/10ps
module sflash_host (
  // System
  input  wire logic       clk,
  input  wire logic       nrst,
  // Request
  input  wire logic       start,
  input  wire logic       write,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  output logic            busy,
  output logic            done,
  output logic [7:0]      rdata,
  // Link
  sflash_if.host          link
);
  typedef enum logic [1:0] {H_IDLE, H_WAKE, H_SHIFT, H_END} hstate_t;
  hstate_t     state;
  logic [23:0] tx;
  logic [4:0]  bits;
  logic [1:0]  div;
  logic        sck;
  logic        ncs;
  logic [7:0]  rx;
  logic        rd_m, rd_s;

  wire logic tick = (div == 2'(sflash_pkg::DIV_HALF - 1));
  wire logic fall = tick & sck;
  wire logic rise = tick & ~sck;

  // Memory output changes after the falling edge; two stages then sample
  always_ff @(posedge clk)
  begin
    rd_m <= link.data_out;
    rd_s <= rd_m;
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      state <= H_IDLE; ncs <= 1'b1; sck <= 1'b0; div <= 2'h0;
      bits <= 5'h0; tx <= 24'h0; rx <= 8'h00; rdata <= 8'h00; done <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      div  <= tick ? 2'h0 : div + 2'h1;
      unique case (state)
        H_IDLE:
          if (start)
          begin
            tx    <= {write ? sflash_pkg::CMD_WRITE : sflash_pkg::CMD_READ, addr, wdata};
            ncs   <= 1'b0;
            bits  <= 5'h0;
            state <= H_SHIFT;
          end
        H_SHIFT:
        begin
          if (rise)
          begin
            sck <= 1'b1;
            rx  <= {rx[6:0], rd_s};
          end
          if (fall)
          begin
            sck  <= 1'b0;
            tx   <= {tx[22:0], 1'b0};
            bits <= bits + 5'h1;
            if (bits == 5'd23)
              state <= H_END;
          end
        end
        H_END:
          if (tick)
          begin
            ncs   <= 1'b1;
            rdata <= rx;
            done  <= 1'b1;
            state <= H_IDLE;
          end
        default: state <= H_IDLE;
      endcase
    end
  end

  assign busy                 = (state != H_IDLE);
  assign link.serial_clock_in = sck;
  assign link.select_n        = ncs;
  assign link.serial_data_in  = tx[23];
endmodule : sflash_host

/* File: hw/sflash_if.sv */
// Four-wire serial link between the host and the memory.
// Assumes the bench resolves the tri-stated data line from the enable.
`timescale 1ns/10ps
interface sflash_if;
  logic serial_clock_in;
  logic select_n;
  logic serial_data_in;
  logic data_out;
  logic data_oe_n;
  modport memory (
    input  serial_clock_in,
    input  select_n,
    input  serial_data_in,
    output data_out,
    output data_oe_n
  );
  modport host (
    output serial_clock_in,
    output select_n,
    output serial_data_in,
    input  data_out,
    input  data_oe_n
  );
endinterface : sflash_if

/* File: hw/sflash_memory.sv */
// Memory end of the serial configuration port.
// Assumes the link clock stops outside frames; state is cleared by select.
// Summary of operation
// - Select high: deselected, data output tri-stated
// - Select low: active, accepts instructions
// - Host frames each instruction with select
// - No operation before first select falling edge
// - Memory samples input on rising clock
// - Output updates after falling clock edges
// - Host sources serial clock, never memory
// - Host captures read data on rising
// - Host presents write data on input line
// - Output driven only while select low
`timescale 1ns/10ps
module sflash_memory #(
  parameter int unsigned DEPTH = sflash_pkg::MEM_DEPTH
) (
  // Link
  sflash_if.memory link,
  // Local
  input  wire logic nrst,
  output logic      armed
);
  localparam int unsigned AW = $clog2(DEPTH);
  typedef enum logic [1:0] {ST_CMD, ST_ADDR, ST_DATA} phase_t;

  logic [7:0]  mem [DEPTH];
  phase_t      phase;
  logic [3:0]  count;
  logic [7:0]  shift;
  logic [7:0]  cmd;
  logic [AW-1:0] addr;
  logic [7:0]  out_word;
  logic        out_bit;
  logic        seen_select;
  logic        drive;

  wire logic [7:0] next_shift = {shift[6:0], link.serial_data_in};
  wire logic       byte_done  = (count == 4'h7);
  wire logic       active     = ~link.select_n & seen_select;

  // Select falling edge arms the part; the async clear disarms it until the next one
  always_ff @(negedge link.select_n or negedge nrst)
  begin
    if (!nrst)
      seen_select <= 1'b0;
    else
      seen_select <= 1'b1;
  end
  assign armed = seen_select;

  // Link clock may stop after a frame, so select resets frame state
  always_ff @(posedge link.serial_clock_in or posedge link.select_n)
  begin
    if (link.select_n)
    begin
      phase <= ST_CMD;
      count <= 4'h0;
    end
    else if (active)
    begin
      shift <= next_shift;
      count <= byte_done ? 4'h0 : count + 4'h1;
      if (byte_done)
      begin
        unique case (phase)
          ST_CMD:  begin cmd <= next_shift; phase <= ST_ADDR; end
          ST_ADDR: begin addr <= next_shift[AW-1:0]; phase <= ST_DATA; end
          ST_DATA:
          begin
            addr <= addr + 1'b1;
          end
        endcase
      end
    end
  end

  wire logic reading   = active && phase == ST_DATA && cmd == sflash_pkg::CMD_READ;
  wire logic write_now = active && byte_done && phase == ST_DATA
                         && cmd == sflash_pkg::CMD_WRITE;

  // Array kept out of the select-cleared process so it stays a plain RAM
  always_ff @(posedge link.serial_clock_in)
  begin
    if (write_now)
      mem[addr] <= next_shift;
  end

  // Output shifts on falling edges, MSB first; select high clears it so
  // a read frame leaves no drive behind for the next frame
  always_ff @(negedge link.serial_clock_in or posedge link.select_n)
  begin
    if (link.select_n)
    begin
      out_bit  <= 1'b0;
      out_word <= 8'h00;
      drive    <= 1'b0;
    end
    else if (reading)
    begin
      out_bit  <= (count == 4'h0) ? mem[addr][7] : out_word[7];
      out_word <= (count == 4'h0) ? {mem[addr][6:0], 1'b0} : {out_word[6:0], 1'b0};
      drive    <= 1'b1;
    end
    else
    begin
      out_bit  <= 1'b0;
      out_word <= 8'h00;
      drive    <= 1'b0;
    end
  end

  assign link.data_out  = out_bit;
  assign link.data_oe_n = ~(active & drive);
endmodule : sflash_memory

/* File: hw/sflash_pkg.sv */
// Shared constants for the serial configuration memory port.
// Assumes both ends are built from this package; no imports.
package sflash_pkg;
  localparam int unsigned CMD_BITS       = 8;
  localparam int unsigned DATA_BITS      = 8;
  localparam int unsigned SYS_CLK_NS     = 50;
  // Half link period in clk cycles; at least 3 so read data has crossed
  // the host's two-stage synchroniser before the next rising edge
  localparam int unsigned DIV_HALF       = 3;
  localparam logic [7:0]  CMD_READ       = 8'h03;
  localparam logic [7:0]  CMD_WRITE      = 8'h02;
  localparam int unsigned MEM_DEPTH      = 256;
  localparam logic [7:0]  MEM_RESET_WORD = 8'hff;
endpackage : sflash_pkg
